// ### src/analog_scaling_pkg.sv
package analog_scaling_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int CHANNELS = 2;
	localparam int RAW_WIDTH = 10;
	localparam int DATA_WIDTH = 32;
	localparam int ADDR_WIDTH = 8;
	localparam int DIV_COUNT_WIDTH = 5;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] READING_COUNT_OFFSET = 8'h00;
	localparam logic [7:0] READING_ONE_OFFSET = 8'h04;
	localparam logic [7:0] READING_TWO_OFFSET = 8'h08;
	localparam logic [7:0] OFFSET_COUNT_OFFSET = 8'h0C;
	localparam logic [7:0] OFFSET_ONE_OFFSET = 8'h10;
	localparam logic [7:0] OFFSET_TWO_OFFSET = 8'h14;
	localparam logic [7:0] DIVISOR_COUNT_OFFSET = 8'h18;
	localparam logic [7:0] DIVISOR_ONE_OFFSET = 8'h1C;
	localparam logic [7:0] DIVISOR_TWO_OFFSET = 8'h20;
	localparam logic [7:0] INPUT_MODE_OFFSET = 8'h24;
	localparam logic [7:0] PHYSICAL_ONE_OFFSET = 8'h28;
	localparam logic [7:0] PHYSICAL_TWO_OFFSET = 8'h2C;

	// ****************************************
	// values after reset and last divider step
	// ****************************************
	localparam logic [31:0] CHANNEL_COUNT_VALUE = 32'h0000_0002;
	localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
	localparam logic [31:0] DIVISOR_RESET = 32'h0000_0001;
	localparam logic [31:0] READING_RESET = 32'h0000_0000;
	localparam logic [1:0] INPUT_MODE_RESET = 2'h0;
	localparam logic [4:0] DIV_LAST_STEP = 5'h1F;

	// ****************************************
	// physical scaling
	// ****************************************
	localparam logic signed [31:0] VOLT_MIDSCALE = 32'sh0000_0200;
	localparam logic signed [31:0] FULL_SCALE_MILLI = 32'sh0000_4E20;
	localparam int COUNT_SHIFT = 10;

	// ****************************************
	// bus responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic valid;
		logic [RAW_WIDTH-1:0] count;
	} adc_sample_type;

	typedef enum logic [1:0] {
		REG_NONE,
		REG_RO,
		REG_RW
	} reg_kind_type;

endpackage

// ### src/signed_divider.sv
`timescale 1ns/100ps
`default_nettype none
module signed_divider
	import analog_scaling_pkg::*;
(
	// clock, reset and enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// operands
	input wire logic start_in,
	input wire logic [31:0] dividend_in,
	input wire logic [31:0] divisor_in,
	// result
	output logic busy_out,
	output logic done_out,
	output logic [31:0] quotient_out
);

	typedef enum logic {
		DIV_IDLE,
		DIV_RUN
	} div_state_type;

	div_state_type state_q;
	logic [4:0] step_q;
	logic [32:0] rem_q;
	logic [31:0] quo_q;
	logic [31:0] dmag_q;
	logic neg_q;
	logic [32:0] rem_shift;
	logic [32:0] diff;

	assign rem_shift = {rem_q[31:0], quo_q[31]};
	assign diff = rem_shift - {1'b0, dmag_q};
	assign busy_out = (state_q == DIV_RUN);

	// ****************************************
	// restoring division on magnitudes
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= DIV_IDLE;
			step_q <= 5'h0;
			rem_q <= 33'h0_0000_0000;
			quo_q <= 32'h0000_0000;
			dmag_q <= 32'h0000_0000;
			neg_q <= 1'b0;
			done_out <= 1'b0;
			quotient_out <= 32'h0000_0000;
		end else if (ce_in) begin
			done_out <= 1'b0;
			case (state_q)
				DIV_IDLE: begin
					if (start_in) begin
						quo_q <= dividend_in[31] ? -dividend_in : dividend_in;
						dmag_q <= divisor_in[31] ? -divisor_in : divisor_in;
						neg_q <= dividend_in[31] ^ divisor_in[31];
						rem_q <= 33'h0_0000_0000;
						step_q <= 5'h0;
						state_q <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					if (!diff[32]) begin
						rem_q <= diff;
						quo_q <= {quo_q[30:0], 1'b1};
					end else begin
						rem_q <= rem_shift;
						quo_q <= {quo_q[30:0], 1'b0};
					end
					step_q <= step_q + 5'h1;
					if (step_q == DIV_LAST_STEP) begin
						// truncation toward zero by signing the magnitude quotient
						quotient_out <= neg_q ? -{quo_q[30:0], !diff[32]} :
							{quo_q[30:0], !diff[32]};
						done_out <= 1'b1;
						state_q <= DIV_IDLE;
					end
				end
				default: begin
					state_q <= DIV_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ### src/analog_input_scaling.sv
// Summary of operation
// - Each channel adds its signed offset to the raw count before dividing.
// - The offset sum is divided by the channel divisor and the quotient is the reading.
// - With offset zero and divisor one the reading equals the raw count.
// - Divisors reset to one and offsets to zero, and both are writable per channel.
// - Exactly two channels exist and the reading, offset and divisor tables each have a read-only count of two.
// - In voltage mode a count x maps to (x - 512) * 20 V / 1024, in millivolts.
// - In current mode a count x maps to x * 20 mA / 1024, in microamperes.
// - Each reading is a read-only signed 32-bit value, zero after reset.
// - Offsets are held per channel as signed 32-bit values, first then second.
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling
	import analog_scaling_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// converter samples
	input wire adc_sample_type [CHANNELS-1:0] adc_sample_in,
	// scaled readings
	output logic [CHANNELS-1:0][31:0] reading_out,
	// axi4-lite write address
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_in,
	input wire logic [2:0] s_axi_awprot_in,
	// axi4-lite write data
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// axi4-lite write response
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// axi4-lite read address
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr_in,
	input wire logic [2:0] s_axi_arprot_in,
	// axi4-lite read data
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out
);

	// ****************************************
	// functions
	// ****************************************
	function automatic reg_kind_type reg_kind(input logic [ADDR_WIDTH-1:0] addr);
		reg_kind_type kind;
		kind = REG_NONE;
		case (addr)
			READING_COUNT_OFFSET, READING_ONE_OFFSET, READING_TWO_OFFSET: kind = REG_RO;
			OFFSET_COUNT_OFFSET, DIVISOR_COUNT_OFFSET: kind = REG_RO;
			PHYSICAL_ONE_OFFSET, PHYSICAL_TWO_OFFSET: kind = REG_RO;
			OFFSET_ONE_OFFSET, OFFSET_TWO_OFFSET: kind = REG_RW;
			DIVISOR_ONE_OFFSET, DIVISOR_TWO_OFFSET: kind = REG_RW;
			INPUT_MODE_OFFSET: kind = REG_RW;
			default: kind = REG_NONE;
		endcase
		return kind;
	endfunction

	function automatic logic [31:0] merge_strobes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] result;
		result = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return result;
	endfunction

	function automatic logic [CHANNELS-1:0] setting_owner(input logic [ADDR_WIDTH-1:0] addr);
		logic [CHANNELS-1:0] owner;
		owner = '0;
		case (addr)
			OFFSET_ONE_OFFSET, DIVISOR_ONE_OFFSET: owner[0] = 1'b1;
			OFFSET_TWO_OFFSET, DIVISOR_TWO_OFFSET: owner[1] = 1'b1;
			default: owner = '0;
		endcase
		return owner;
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [CHANNELS-1:0][31:0] offset_q;
	logic [CHANNELS-1:0][31:0] divisor_q;
	logic [CHANNELS-1:0][31:0] reading_q;
	logic [CHANNELS-1:0][31:0] physical;
	logic [CHANNELS-1:0][31:0] physical_q;
	logic [CHANNELS-1:0][RAW_WIDTH-1:0] raw_q;
	logic [CHANNELS-1:0] pending_q;
	logic [CHANNELS-1:0] setting_wr;
	logic [CHANNELS-1:0] div_busy;
	logic [CHANNELS-1:0] div_done;
	logic [CHANNELS-1:0][31:0] div_quotient;
	logic [1:0] mode_q;
	logic aw_full_q;
	logic w_full_q;
	logic [ADDR_WIDTH-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_fire;
	logic aw_take;
	logic w_take;
	logic ar_take;
	reg_kind_type wr_kind;

	assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
	assign w_take = s_axi_wvalid_in && s_axi_wready_out;
	assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_out;
	assign wr_kind = reg_kind(awaddr_q);
	assign reading_out = reading_q;

	// ****************************************
	// write channels
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end else if (ce_in) begin
			if (aw_take) begin
				aw_full_q <= 1'b1;
				awaddr_q <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end else if (!aw_full_q && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (w_take) begin
				w_full_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end else if (!w_full_q && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				case (wr_kind)
					REG_RW: s_axi_bresp_out <= RESP_OKAY;
					REG_RO: s_axi_bresp_out <= RESP_SLVERR;
					default: s_axi_bresp_out <= RESP_DECERR;
				endcase
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// ****************************************
	// settings registers
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			offset_q <= {CHANNELS{OFFSET_RESET}};
			divisor_q <= {CHANNELS{DIVISOR_RESET}};
			mode_q <= INPUT_MODE_RESET;
		end else if (ce_in && wr_fire) begin
			case (awaddr_q)
				OFFSET_ONE_OFFSET: offset_q[0] <= merge_strobes(offset_q[0], wdata_q, wstrb_q);
				OFFSET_TWO_OFFSET: offset_q[1] <= merge_strobes(offset_q[1], wdata_q, wstrb_q);
				DIVISOR_ONE_OFFSET: divisor_q[0] <= merge_strobes(divisor_q[0], wdata_q, wstrb_q);
				DIVISOR_TWO_OFFSET: divisor_q[1] <= merge_strobes(divisor_q[1], wdata_q, wstrb_q);
				INPUT_MODE_OFFSET: begin
					if (wstrb_q[0]) begin
						mode_q <= wdata_q[1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		setting_wr = '0;
		if (wr_fire) begin
			setting_wr = setting_owner(awaddr_q);
		end
	end

	// ****************************************
	// per-channel scaling
	// ****************************************
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
		logic start;
		logic [31:0] sum;
		logic signed [31:0] centred;
		logic signed [31:0] scaled;

		assign start = pending_q[ch] && !div_busy[ch];
		assign sum = 32'(raw_q[ch]) + offset_q[ch];
		assign centred = mode_q[ch] ? signed'(32'(raw_q[ch])) :
			signed'(32'(raw_q[ch])) - VOLT_MIDSCALE;
		assign scaled = centred * FULL_SCALE_MILLI;
		assign physical[ch] = 32'(scaled >>> COUNT_SHIFT);

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				raw_q[ch] <= '0;
				pending_q[ch] <= 1'b0;
			end else if (ce_in) begin
				if (adc_sample_in[ch].valid) begin
					raw_q[ch] <= adc_sample_in[ch].count;
				end
				// a new event wins over the start that consumes the old one
				pending_q[ch] <= (pending_q[ch] && !start) || adc_sample_in[ch].valid ||
					setting_wr[ch];
			end
		end

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				reading_q[ch] <= READING_RESET;
			end else if (ce_in && div_done[ch]) begin
				reading_q[ch] <= div_quotient[ch];
			end
		end

		// physical value held for the read mux
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				physical_q[ch] <= READING_RESET;
			end else if (ce_in) begin
				physical_q[ch] <= physical[ch];
			end
		end

		signed_divider u_divider (
			.clk_in(clk_in),
			.rst_in(rst_in),
			.ce_in(ce_in),
			.start_in(start),
			.dividend_in(sum),
			.divisor_in(divisor_q[ch]),
			.busy_out(div_busy[ch]),
			.done_out(div_done[ch]),
			.quotient_out(div_quotient[ch])
		);
	end

	// ****************************************
	// read channels
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (ce_in) begin
			if (ar_take) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out <= 1'b1;
				s_axi_rresp_out <= (reg_kind(s_axi_araddr_in) == REG_NONE) ? RESP_DECERR :
					RESP_OKAY;
				case (s_axi_araddr_in)
					READING_COUNT_OFFSET: s_axi_rdata_out <= CHANNEL_COUNT_VALUE;
					OFFSET_COUNT_OFFSET: s_axi_rdata_out <= CHANNEL_COUNT_VALUE;
					DIVISOR_COUNT_OFFSET: s_axi_rdata_out <= CHANNEL_COUNT_VALUE;
					READING_ONE_OFFSET: s_axi_rdata_out <= reading_q[0];
					READING_TWO_OFFSET: s_axi_rdata_out <= reading_q[1];
					OFFSET_ONE_OFFSET: s_axi_rdata_out <= offset_q[0];
					OFFSET_TWO_OFFSET: s_axi_rdata_out <= offset_q[1];
					DIVISOR_ONE_OFFSET: s_axi_rdata_out <= divisor_q[0];
					DIVISOR_TWO_OFFSET: s_axi_rdata_out <= divisor_q[1];
					INPUT_MODE_OFFSET: s_axi_rdata_out <= {30'h0000_0000, mode_q};
					PHYSICAL_ONE_OFFSET: s_axi_rdata_out <= physical_q[0];
					PHYSICAL_TWO_OFFSET: s_axi_rdata_out <= physical_q[1];
					default: s_axi_rdata_out <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid_out && s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
				s_axi_arready_out <= 1'b1;
			end else if (!s_axi_rvalid_out) begin
				s_axi_arready_out <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ### tb/analog_input_scaling_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module analog_input_scaling_assertions
	import analog_scaling_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// watched ports
	input wire adc_sample_type [CHANNELS-1:0] adc_sample_in,
	input wire logic [CHANNELS-1:0][31:0] reading_out,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [ADDR_WIDTH-1:0] s_axi_araddr_in,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out
);
	logic [6:0] quiet_q;
	logic ar_take;
	logic wr_take;
	logic cause;
	assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
	assign wr_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	assign cause = adc_sample_in[0].valid || adc_sample_in[1].valid ||
		(s_axi_wvalid_in && s_axi_wready_out);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// cycles since last recompute cause
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			quiet_q <= 7'h00;
		end else if (cause) begin
			quiet_q <= 7'h00;
		end else if (quiet_q != 7'h7F) begin
			quiet_q <= quiet_q + 7'h01;
		end
	end
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid_out) else $error("no write answer");
	rd_answer_a: assert property (ar_take |=> s_axi_rvalid_out) else $error("no read answer");
	count_read_a: assert property (ar_take && (s_axi_araddr_in == READING_COUNT_OFFSET
		|| s_axi_araddr_in == OFFSET_COUNT_OFFSET || s_axi_araddr_in == DIVISOR_COUNT_OFFSET)
		|=> s_axi_rdata_out == 32'h0000_0002) else $error("channel count wrong");
	unmapped_read_a: assert property (ar_take && s_axi_araddr_in > PHYSICAL_TWO_OFFSET
		|=> s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == RESP_DECERR)
		else $error("unmapped read answered");
	reading_read_a: assert property (ar_take && s_axi_araddr_in == READING_ONE_OFFSET
		|=> s_axi_rdata_out == $past(reading_out[0])) else $error("reading mismatch");
	ro_write_a: assert property (wr_take && s_axi_awaddr_in == READING_COUNT_OFFSET
		|-> ##2 s_axi_bresp_out == RESP_SLVERR) else $error("read-only write accepted");
	reading_reset_a: assert property ($fell(rst_in) |-> reading_out == '0)
		else $error("reading not zero after reset");
	reading_quiet_a: assert property (reading_out != $past(reading_out) |-> quiet_q < 7'h50)
		else $error("reading changed without cause");
	cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
	cover property (s_axi_rvalid_out && s_axi_rresp_out == RESP_DECERR);
	cover property (reading_out != $past(reading_out));
endmodule
bind analog_input_scaling analog_input_scaling_assertions checker_i (.clk_in(clk_in),
	.rst_in(rst_in), .adc_sample_in(adc_sample_in), .reading_out(reading_out),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rresp_out(s_axi_rresp_out));
`default_nettype wire

// ### tb/adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_model
	import analog_scaling_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// conversion requests
	input wire logic [CHANNELS-1:0] fire_in,
	input wire logic [CHANNELS-1:0][RAW_WIDTH-1:0] value_in,
	// samples
	output var adc_sample_type [CHANNELS-1:0] sample_out
);
	// one-cycle pulse, count inverted between samples
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sample_out <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				sample_out[i].valid <= fire_in[i];
				sample_out[i].count <= fire_in[i] ? value_in[i] : ~sample_out[i].count;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_analog_input_scaling.sv
`timescale 1ns/100ps
`default_nettype none
module tb_analog_input_scaling
	import analog_scaling_pkg::*;
;
	logic clk_in = 0;
	logic rst_in = 1;
	logic [1:0] fire = '0;
	logic [1:0][9:0] vals = '0;
	adc_sample_type [CHANNELS-1:0] samp;
	logic [CHANNELS-1:0][31:0] reading;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	int err_total = 0;
	int comparisons = 0;
	logic [7:0] ra [9] = '{READING_COUNT_OFFSET, READING_ONE_OFFSET, READING_TWO_OFFSET,
		OFFSET_COUNT_OFFSET, OFFSET_ONE_OFFSET, OFFSET_TWO_OFFSET, DIVISOR_COUNT_OFFSET,
		DIVISOR_ONE_OFFSET, DIVISOR_TWO_OFFSET};
	logic [31:0] rv [9] = '{32'h2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h0, 32'h2, 32'h1, 32'h1};
	always #5 clk_in = ~clk_in;
	adc_model adc (.clk_in(clk_in), .rst_in(rst_in), .fire_in(fire), .value_in(vals),
		.sample_out(samp));
	analog_input_scaling dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
		.adc_sample_in(samp), .reading_out(reading), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_up();
		err_total++;
		$display("[FAIL] %0t bus gave no answer", $time);
		complete_run();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk_in);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 0;
			end
			if (bvalid === 1'b1) break;
		end
		if (n == 60) give_up();
		bready <= 0;
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 60; n++) begin
			@(posedge clk_in);
			if (arready === 1'b1) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		if (n == 60) give_up();
		rready <= 0;
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
	endtask
	task automatic sample(input logic [9:0] c0, input logic [9:0] c1);
		@(posedge clk_in);
		fire <= 2'h3;
		vals <= {c1, c0};
		@(posedge clk_in);
		fire <= 2'h0;
		repeat (80) @(posedge clk_in);
	endtask
	function automatic logic [31:0] scale(input logic [9:0] x, input logic [31:0] o,
		input logic [31:0] d);
		return $signed({22'h0, x} + o) / $signed(d);
	endfunction
	function automatic logic [31:0] phys(input logic [9:0] x, input logic cur);
		int v;
		v = cur ? int'(x) * 20000 : (int'(x) - 512) * 20000;
		return v >>> 10;
	endfunction
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 0;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i], RESP_OKAY);
		$display("test reset values done");
		wr(READING_COUNT_OFFSET, 32'h0000_0007, RESP_SLVERR);
		wr(READING_ONE_OFFSET, 32'h1234_5678, RESP_SLVERR);
		wr(8'h30, 32'h0000_0005, RESP_DECERR);
		rd(8'h30, 32'h0000_0000, RESP_DECERR);
		rd(READING_COUNT_OFFSET, 32'h0000_0002, RESP_OKAY);
		rd(READING_ONE_OFFSET, 32'h0000_0000, RESP_OKAY);
		$display("test refusals done");
		sample(10'h2BC, 10'h005);
		chk(reading[0], 32'h0000_02BC);
		rd(READING_TWO_OFFSET, 32'h0000_0005, RESP_OKAY);
		$display("test presets done");
		wr(OFFSET_ONE_OFFSET, 32'hFFFF_FC18, RESP_OKAY);
		wr(DIVISOR_ONE_OFFSET, 32'h0000_0007, RESP_OKAY);
		wr(OFFSET_TWO_OFFSET, 32'h0000_0064, RESP_OKAY);
		wr(DIVISOR_TWO_OFFSET, 32'hFFFF_FFFD, RESP_OKAY);
		repeat (80) @(posedge clk_in);
		chk(reading[0], scale(10'h2BC, 32'hFFFF_FC18, 32'h0000_0007));
		chk(reading[1], scale(10'h005, 32'h0000_0064, 32'hFFFF_FFFD));
		rd(OFFSET_ONE_OFFSET, 32'hFFFF_FC18, RESP_OKAY);
		rd(DIVISOR_TWO_OFFSET, 32'hFFFF_FFFD, RESP_OKAY);
		sample(10'h3FF, 10'h000);
		chk(reading[0], scale(10'h3FF, 32'hFFFF_FC18, 32'h0000_0007));
		chk(reading[1], scale(10'h000, 32'h0000_0064, 32'hFFFF_FFFD));
		wstrb <= 4'h1;
		wr(OFFSET_TWO_OFFSET, 32'hAAAA_AA55, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFFSET_TWO_OFFSET, 32'h0000_0055, RESP_OKAY);
		$display("test scaling done");
		rd(PHYSICAL_ONE_OFFSET, phys(10'h3FF, 1'b0), RESP_OKAY);
		rd(PHYSICAL_TWO_OFFSET, phys(10'h000, 1'b0), RESP_OKAY);
		wr(INPUT_MODE_OFFSET, 32'h0000_0003, RESP_OKAY);
		rd(PHYSICAL_ONE_OFFSET, phys(10'h3FF, 1'b1), RESP_OKAY);
		rd(PHYSICAL_TWO_OFFSET, phys(10'h000, 1'b1), RESP_OKAY);
		$display("test physical units done");
		@(posedge clk_in);
		rst_in <= 1;
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		rd(DIVISOR_ONE_OFFSET, 32'h0000_0001, RESP_OKAY);
		rd(OFFSET_TWO_OFFSET, 32'h0000_0000, RESP_OKAY);
		chk(reading[0], 32'h0000_0000);
		$display("test second reset done");
		complete_run();
	end
endmodule
`default_nettype wire
